// ### rtl/pai_pkg.sv
// package: register map, field layout and carrier types of the port alias and indirect access block
package pai_pkg;
  localparam logic [7:0] OFS_PORT1_ALIAS = 8'hF9;
  localparam logic [7:0] OFS_PORT2_ALIAS = 8'hFA;
  localparam logic [7:0] OFS_PORT3_ALIAS = 8'hFB;
  localparam logic [7:0] OFS_IND_CONTROL = 8'hB0;
  localparam logic [7:0] OFS_IND_OFFSET = 8'hB1;
  localparam logic [7:0] OFS_IND_DATA = 8'hB2;
  localparam logic [7:0] RST_ALIAS = 8'h00;
  localparam logic [7:0] RST_IND_CONTROL = 8'h00;
  localparam logic [7:0] RST_IND_OFFSET = 8'h00;
  localparam int ALIAS_FIELD_LSB = 1;
  localparam int IND_AUTOINC_BIT = 1;
  localparam int IND_BLOCK_LSB = 2;
  localparam int IND_BLOCK_MSB = 4;
  localparam logic [7:0] IND_CONTROL_MASK = 8'h1E;
  localparam int NUM_ALIAS = 3;

  // one register access as decoded by the i2c target
  typedef struct packed {
    logic valid;
    logic write;
    logic [6:0] dev_addr;
    logic [7:0] offset;
    logic [7:0] wdata;
  } pai_req_t;

  // access forwarded to a secondary map
  typedef struct packed {
    logic write;
    logic read;
    logic [2:0] block;
    logic [7:0] offset;
    logic [7:0] wdata;
  } pai_ind_t;
endpackage

// ### rtl/pai_regs.sv
// port alias decoders and indirect access window of the deserializer hub register file
// Notes on behaviour
// - ports 1-3 each hold a 7-bit alias in bits 7:1; bit 0 reads zero.
// - nonzero alias match decodes access as that port's registers, no paging needed.
// - alias field of zero disables that port's alias decoder.
// - alias accesses also reach all shared registers, like the primary address.
// - port 2 and 3 alias registers reset to zero.
// - secondary maps reachable only via indirect registers at 0xB0 to 0xB2.
// - indirect control selects target block and holds auto-increment enable.
// - indirect offset sets location; data register accesses block at that offset.
// - with auto-increment, offset advances by one after each data access.
// - primary address reaches the port chosen by the port select register.
`timescale 1ns/1ps
`default_nettype none
module pai_regs (
  input wire logic clock_in,                    // 20 MHz core clock
  input wire logic reset_in,                    // synchronous, active high
  input wire pai_pkg::pai_req_t req_in,         // decoded i2c register access
  input wire logic [6:0] primary_addr_in,       // device primary i2c address
  input wire logic [1:0] page_port_in,          // port chosen by port select register
  input wire logic [7:0] ext_rdata_in,          // read data from rest of main map
  input wire logic [7:0] ind_rdata_in,          // read data from selected secondary map
  output logic hit_out,                         // access addressed to this device
  output logic ext_req_out,                     // main map access not held here
  output logic [1:0] port_out,                  // receive port for port-specific registers
  output pai_pkg::pai_ind_t ind_out,            // secondary map access
  output logic [7:0] rdata_out,                 // read data, one cycle after request
  output logic rdata_valid_out                  // read data valid pulse
);
  import pai_pkg::*;

  logic [7:0] alias_reg [NUM_ALIAS];
  logic [7:0] ind_control;
  logic [7:0] ind_offset;
  logic [NUM_ALIAS-1:0] alias_hit;
  logic primary_hit;
  logic local_hit;
  logic data_access;
  logic [7:0] next_rdata;

  function automatic logic alias_match(input logic [7:0] areg, input logic [6:0] addr);
    // zero means decoder off, so address 0 never matches an alias
    alias_match = (areg[7:ALIAS_FIELD_LSB] != 7'h00) && (areg[7:ALIAS_FIELD_LSB] == addr);
  endfunction

  always_comb begin
    for (int i = 0; i < NUM_ALIAS; i++) begin
      alias_hit[i] = req_in.valid && alias_match(alias_reg[i], req_in.dev_addr);
    end
  end

  assign primary_hit = req_in.valid && (req_in.dev_addr == primary_addr_in);
  assign hit_out = primary_hit || (|alias_hit);

  // an alias wins over paging, so an alias never depends on the port select register
  always_comb begin
    if (alias_hit[0]) begin
      port_out = 2'h1;
    end else if (alias_hit[1]) begin
      port_out = 2'h2;
    end else if (alias_hit[2]) begin
      port_out = 2'h3;
    end else begin
      port_out = page_port_in;
    end
  end

  assign local_hit = (req_in.offset == OFS_PORT1_ALIAS) || (req_in.offset == OFS_PORT2_ALIAS) ||
                     (req_in.offset == OFS_PORT3_ALIAS) || (req_in.offset == OFS_IND_CONTROL) ||
                     (req_in.offset == OFS_IND_OFFSET) || (req_in.offset == OFS_IND_DATA);
  assign ext_req_out = hit_out && !local_hit;
  assign data_access = hit_out && (req_in.offset == OFS_IND_DATA);

  assign ind_out.write = data_access && req_in.write;
  assign ind_out.read = data_access && !req_in.write;
  assign ind_out.block = ind_control[IND_BLOCK_MSB:IND_BLOCK_LSB];
  assign ind_out.offset = ind_offset;
  assign ind_out.wdata = req_in.wdata;

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      for (int i = 0; i < NUM_ALIAS; i++) begin
        alias_reg[i] <= RST_ALIAS;
      end
    end else if (hit_out && req_in.write) begin
      for (int i = 0; i < NUM_ALIAS; i++) begin
        if (req_in.offset == OFS_PORT1_ALIAS + 8'(i)) begin
          alias_reg[i] <= {req_in.wdata[7:ALIAS_FIELD_LSB], 1'b0};
        end
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      ind_control <= RST_IND_CONTROL;
    end else if (hit_out && req_in.write && req_in.offset == OFS_IND_CONTROL) begin
      ind_control <= req_in.wdata & IND_CONTROL_MASK;
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      ind_offset <= RST_IND_OFFSET;
    end else if (hit_out && req_in.write && req_in.offset == OFS_IND_OFFSET) begin
      ind_offset <= req_in.wdata;
    end else if (data_access && ind_control[IND_AUTOINC_BIT]) begin
      ind_offset <= ind_offset + 8'h01;
    end
    // otherwise held, including across data accesses while auto-increment is off
  end

  // read data is taken in the request cycle, so both read sources must answer combinationally
  always_comb begin
    next_rdata = ext_rdata_in;
    if (req_in.offset == OFS_PORT1_ALIAS) next_rdata = alias_reg[0];
    if (req_in.offset == OFS_PORT2_ALIAS) next_rdata = alias_reg[1];
    if (req_in.offset == OFS_PORT3_ALIAS) next_rdata = alias_reg[2];
    if (req_in.offset == OFS_IND_CONTROL) next_rdata = ind_control;
    if (req_in.offset == OFS_IND_OFFSET) next_rdata = ind_offset;
    if (req_in.offset == OFS_IND_DATA) next_rdata = ind_rdata_in;
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      rdata_out <= 8'h00;
      rdata_valid_out <= 1'b0;
    end else begin
      rdata_valid_out <= hit_out && !req_in.write;
      if (hit_out && !req_in.write) begin
        rdata_out <= next_rdata;
      end
    end
  end

  sequence s_offset_write;
    hit_out && req_in.write && req_in.offset == OFS_IND_OFFSET;
  endsequence

  sequence s_offset_readback;
    hit_out && !req_in.write && req_in.offset == OFS_IND_OFFSET;
  endsequence

  a_alias_reserved: assert property (@(posedge clock_in) disable iff (reset_in)
    alias_reg[0][0] == 1'b0 && alias_reg[1][0] == 1'b0 && alias_reg[2][0] == 1'b0)
    else $error("alias reserved bit set");

  a_alias_write: assert property (@(posedge clock_in) disable iff (reset_in)
    hit_out && req_in.write && req_in.offset == OFS_PORT2_ALIAS |=>
      alias_reg[1] == {$past(req_in.wdata[7:1]), 1'b0})
    else $error("port2 alias not stored");

  a_alias_zero_off: assert property (@(posedge clock_in) disable iff (reset_in)
    (|alias_hit) |-> ((alias_hit[0] -> alias_reg[0] != 8'h00) && (alias_hit[1] -> alias_reg[1] != 8'h00)
      && (alias_hit[2] -> alias_reg[2] != 8'h00)))
    else $error("disabled alias decoded");

  a_alias_port: assert property (@(posedge clock_in) disable iff (reset_in)
    alias_hit[2] && !alias_hit[0] && !alias_hit[1] |-> port_out == 2'h3 && hit_out)
    else $error("alias did not select port 3");

  a_page_select: assert property (@(posedge clock_in) disable iff (reset_in)
    primary_hit && alias_hit == 3'b000 |-> port_out == page_port_in)
    else $error("primary access ignored port select");

  a_reset_alias: assert property (@(posedge clock_in)
    $past(reset_in) |-> alias_reg[1] == 8'h00 && alias_reg[2] == 8'h00)
    else $error("alias not zero after reset");

  a_shared_read: assert property (@(posedge clock_in) disable iff (reset_in)
    alias_hit[0] && !req_in.write && req_in.offset == OFS_IND_OFFSET |=>
      rdata_valid_out && rdata_out == $past(ind_offset))
    else $error("shared register unreachable via alias");

  a_ind_strobe: assert property (@(posedge clock_in) disable iff (reset_in)
    (ind_out.write || ind_out.read) |-> hit_out && req_in.offset == OFS_IND_DATA
      && ind_out.block == ind_control[4:2])
    else $error("secondary map strobe outside data register");

  a_autoinc_step: assert property (@(posedge clock_in) disable iff (reset_in)
    data_access && ind_control[1] |=> ind_offset == $past(ind_offset) + 8'h01)
    else $error("offset did not advance");

  a_offset_hold: assert property (@(posedge clock_in) disable iff (reset_in)
    data_access && !ind_control[1] |=> $stable(ind_offset) [*1] ##0 ind_out.offset == $past(ind_offset))
    else $error("offset moved without auto-increment");

  a_offset_set: assert property (@(posedge clock_in) disable iff (reset_in)
    s_offset_write ##1 s_offset_readback |=> rdata_out == $past(req_in.wdata, 2))
    else $error("offset write not read back");

  sequence s_data_read;
    hit_out && !req_in.write && req_in.offset == OFS_IND_DATA;
  endsequence

  a_read_pulse: assert property (@(posedge clock_in) disable iff (reset_in)
    hit_out && !req_in.write |=> rdata_valid_out)
    else $error("read data valid missing");

  a_miss_quiet: assert property (@(posedge clock_in) disable iff (reset_in)
    !hit_out |=> !rdata_valid_out)
    else $error("read answered without address match");

  a_ind_read_data: assert property (@(posedge clock_in) disable iff (reset_in)
    s_data_read |=> rdata_out == $past(ind_rdata_in))
    else $error("indirect read data not returned");

  a_ctl_reserved: assert property (@(posedge clock_in) disable iff (reset_in)
    (ind_control & ~IND_CONTROL_MASK) == 8'h00)
    else $error("indirect control reserved bit set");

  a_port1_alias: assert property (@(posedge clock_in) disable iff (reset_in)
    alias_hit[0] |-> port_out == 2'h1 && hit_out)
    else $error("alias did not select port 1");

  a_port2_alias: assert property (@(posedge clock_in) disable iff (reset_in)
    alias_hit[1] && !alias_hit[0] |-> port_out == 2'h2 && hit_out)
    else $error("alias did not select port 2");

  // shared registers outside this block are reached through the same pass-through for every address
  a_ext_forward: assert property (@(posedge clock_in) disable iff (reset_in)
    hit_out && !req_in.write && !local_hit |=> rdata_out == $past(ext_rdata_in))
    else $error("shared register read not forwarded");
endmodule
`default_nettype wire

// ### verif/pai_ind_mem.sv
// secondary register maps answering the indirect access window
`timescale 1ns/1ps
`default_nettype none
module pai_ind_mem (
  input wire logic clock_in,            // core clock
  input wire pai_pkg::pai_ind_t ind_in, // forwarded secondary map access
  output logic [7:0] rdata_out          // read data at selected block and offset
);
  import pai_pkg::*;
  // never-written locations read unknown, so a stale address cannot pass a compare
  logic [7:0] mem [0:2047];
  assign rdata_out = mem[{ind_in.block, ind_in.offset}];
  always_ff @(posedge clock_in) begin
    if (ind_in.write) begin
      mem[{ind_in.block, ind_in.offset}] <= ind_in.wdata;
    end
  end
endmodule
`default_nettype wire

// ### verif/testbench.sv
// self-checking bench for the port alias decoders and indirect access window
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import pai_pkg::*;
  localparam logic [6:0] PRI = 7'h50;
  logic clock_in, reset_in, hit_out, ext_req_out, rdata_valid_out;
  pai_req_t req_in;
  pai_ind_t ind_out;
  logic [1:0] page_port_in, port_out;
  logic [7:0] rdata_out, ind_rdata_in;
  logic [3:0] obs;
  int num_errors = 0, n_tests = 0, cyc = 0;
  pai_regs dut (.clock_in(clock_in), .reset_in(reset_in), .req_in(req_in), .primary_addr_in(PRI),
    .page_port_in(page_port_in), .ext_rdata_in(8'h5A), .ind_rdata_in(ind_rdata_in), .hit_out(hit_out),
    .ext_req_out(ext_req_out), .port_out(port_out), .ind_out(ind_out), .rdata_out(rdata_out),
    .rdata_valid_out(rdata_valid_out));
  pai_ind_mem far (.clock_in(clock_in), .ind_in(ind_out), .rdata_out(ind_rdata_in));
  task automatic finish_test();
    if (num_errors == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one request, then an idle cycle; obs keeps hit, ext_req and port of the request cycle
  task automatic acc(input logic [6:0] dev, input logic is_wr, input logic [7:0] ofs, input logic [7:0] wd);
    @(posedge clock_in) req_in <= {1'b1, is_wr, dev, ofs, wd};
    #1 obs = {hit_out, ext_req_out, port_out};
    @(posedge clock_in) req_in.valid <= 1'b0;
    #1;
  endtask
  task automatic wr(input logic [6:0] dev, input logic [7:0] ofs, input logic [7:0] wd);
    acc(dev, 1'b1, ofs, wd);
  endtask
  task automatic rd(input logic [6:0] dev, input logic [7:0] ofs, input logic [7:0] exp);
    acc(dev, 1'b0, ofs, 8'h00);
    chk(16'({rdata_valid_out, rdata_out}), 16'({1'b1, exp}));
  endtask
  initial begin
    clock_in = 1'b0;
    forever #25 clock_in = ~clock_in;
  end
  always @(posedge clock_in) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      finish_test();
    end
  end
  initial begin
    reset_in = 1'b1;
    req_in = '0;
    page_port_in = 2'd0;
    repeat (2) @(posedge clock_in);
    reset_in <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      rd(PRI, OFS_PORT1_ALIAS + 8'(i), RST_ALIAS);
    end
    acc(7'h00, 1'b0, OFS_PORT1_ALIAS, 8'h00);
    chk(16'({obs[3], rdata_valid_out}), 16'h0000);
    for (int i = 1; i < 4; i++) begin
      wr(PRI, OFS_PORT1_ALIAS + 8'(i - 1), 8'(i * 32 + 1));
      rd(PRI, OFS_PORT1_ALIAS + 8'(i - 1), 8'(i * 32));
      rd(7'(i * 16), 8'h10, 8'h5A);
      chk(16'(obs), 16'({2'b11, 2'(i)}));
    end
    rd(7'h10, OFS_IND_OFFSET, RST_IND_OFFSET);
    page_port_in <= 2'd3;
    acc(PRI, 1'b0, 8'h10, 8'h00);
    chk(16'(obs), 16'h000F);
    wr(PRI, OFS_PORT1_ALIAS, 8'h00);
    acc(7'h10, 1'b0, 8'h10, 8'h00);
    chk(16'(obs[3]), 16'h0000);
    wr(PRI, OFS_IND_CONTROL, 8'hFF);
    rd(PRI, OFS_IND_CONTROL, IND_CONTROL_MASK);
    wr(PRI, OFS_IND_CONTROL, 8'h06);
    wr(PRI, OFS_IND_OFFSET, 8'hFE);
    for (int i = 0; i < 3; i++) begin
      wr(PRI, OFS_IND_DATA, 8'hA0 + 8'(i));
      chk(16'(obs[3:2]), 16'h0002);
    end
    rd(PRI, OFS_IND_OFFSET, 8'h01);
    wr(PRI, OFS_IND_CONTROL, 8'h0A);
    wr(PRI, OFS_IND_OFFSET, 8'hFF);
    wr(PRI, OFS_IND_DATA, 8'h77);
    wr(PRI, OFS_IND_CONTROL, 8'h06);
    wr(PRI, OFS_IND_OFFSET, 8'hFE);
    for (int i = 0; i < 3; i++) begin
      rd(PRI, OFS_IND_DATA, 8'hA0 + 8'(i));
    end
    wr(PRI, OFS_IND_CONTROL, 8'h04);
    wr(PRI, OFS_IND_OFFSET, 8'hFF);
    repeat (2) rd(PRI, OFS_IND_DATA, 8'hA1);
    rd(PRI, OFS_IND_OFFSET, 8'hFF);
    // back-to-back offset write and read back, no idle cycle between them
    @(posedge clock_in) req_in <= {1'b1, 1'b1, PRI, OFS_IND_OFFSET, 8'h3C};
    @(posedge clock_in) req_in <= {1'b1, 1'b0, PRI, OFS_IND_OFFSET, 8'h00};
    @(posedge clock_in) req_in.valid <= 1'b0;
    #1 chk(16'({rdata_valid_out, rdata_out}), 16'h013C);
    // second reset in mid-run must clear aliases written earlier
    @(posedge clock_in) reset_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    reset_in <= 1'b0;
    rd(PRI, OFS_PORT2_ALIAS, RST_ALIAS);
    rd(PRI, OFS_PORT3_ALIAS, RST_ALIAS);
    acc(7'h30, 1'b0, 8'h10, 8'h00);
    chk(16'(obs[3]), 16'h0000);
    finish_test();
  end
endmodule
`default_nettype wire
